/* pkg/link_ctrl_consts.svh */
// Offsets, field positions, reset values and timing counts
// Assumes a 250 MHz clock and 16-bit management register words
`ifndef LINK_CTRL_CONSTS_SVH
`define LINK_CTRL_CONSTS_SVH
`define OFS_FEC_DECODER_CTRL 11'h510
`define OFS_LOW_POWER_CODE_SELECT 11'h514
`define OFS_LOW_POWER_CODE_COUNT 11'h515
`define OFS_LINK_UP_UPPER_WAIT 11'h518
`define OFS_GIGABIT_LINK_CTRL 11'h519
`define OFS_COMPLIANCE_PATTERN_CTRL 11'h531
`define RST_FEC_DECODER_CTRL 16'h2d50
`define RST_LOW_POWER_CODE_SELECT 16'h08e3
`define RST_LOW_POWER_CODE_COUNT 16'h0808
`define RST_LINK_UP_UPPER_WAIT 16'h17ce
`define RST_GIGABIT_LINK_CTRL 16'h003d
`define RST_COMPLIANCE_PATTERN_CTRL 16'h0000
`define MASK_FEC_DECODER_CTRL 16'hffff
`define MASK_LOW_POWER_CODE_SELECT 16'h0fff
`define MASK_LOW_POWER_CODE_COUNT 16'h7f7f
`define MASK_LINK_UP_UPPER_WAIT 16'hffff
`define MASK_GIGABIT_LINK_CTRL 16'h7fff
`define MASK_COMPLIANCE_PATTERN_CTRL 16'h01ff
`define BIT_FEC_SKIP 15
`define MSB_OUT_WAKE 11
`define MSB_OUT_SLEEP 8
`define MSB_IN_WAKE 5
`define MSB_IN_SLEEP 2
`define MSB_WAKE_TH 14
`define MSB_SLEEP_TH 6
`define BIT_FORCE_VAL 11
`define BIT_FORCE_EN 10
`define BIT_PATTERN_ORDER 8
`define TIMER_UNIT_US 16
`define CLOCK_MHZ 250
`define CYCLES_PER_UNIT (`TIMER_UNIT_US * `CLOCK_MHZ)
`endif

/* pkg/link_ctrl_pkg.sv */
// Types shared by the link control register block
// Assumes the constants header is compiled alongside
`default_nettype none
package link_ctrl_pkg;
  typedef struct packed {
    logic req;
    logic wr;
    logic [10:0] addr;
    logic [15:0] wdata;
  } mgmt_req_s;
  typedef struct packed {
    logic [2:0] code;
    logic valid;
  } code_group_s;
  typedef enum logic [1:0] {
    wait_idle,
    wait_min,
    wait_max,
    wait_done
  } link_wait_e;
endpackage : link_ctrl_pkg
`default_nettype wire

/* rtl/link_ctrl_regs.sv */
// Gigabit link control registers and the logic they steer
// Assumes a single-cycle management port synchronous to clock
// How it works
// (R1) Bit 15 of the decoder control register set makes receive bypass FEC.
// (R2) Bits 11-9 of the code select register are the wake code sent out.
// (R3) Bits 8-6 of the code select register are the sleep code sent out.
// (R4) A received code equal to bits 5-3 is taken as a wake indication.
// (R5) A received code equal to bits 2-0 is taken as a sleep indication.
// (R6) Wake received is flagged once the run of wake codes reaches bits 14-8.
// (R7) Sleep received is flagged once the run of sleep codes reaches bits 6-0.
// (R8) The link-up upper wait lasts the 16-bit field times 16 us.
// (R9) The link-up lower wait lasts bits 7-0 times 16 us.
// (R10) With force enable bit 10 set, link status is the software value.
// (R11) The forced value in bit 11 is ignored while bit 10 is clear.
// (R12) Pattern four sends T1 then T2 when bit 8 is 0, else T2 then T1.
// (R13) Pattern seven sends the 8-bit data in bits 7-0.
`include "link_ctrl_consts.svh"
`default_nettype none
module link_ctrl_regs
  import link_ctrl_pkg::*;
#(
  parameter int UNIT_CYCLES = `CYCLES_PER_UNIT
) (
  input wire logic clock,
  input wire logic rst,
  input wire mgmt_req_s mgmt,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_ack,
  input wire code_group_s rx_group,
  input wire logic link_up_start,
  input wire logic link_stat_internal,
  output logic fec_decoder_skip,
  output logic [2:0] outgoing_wake_code,
  output logic [2:0] outgoing_sleep_code,
  output logic wake_cmd_received,
  output logic sleep_cmd_received,
  output logic min_wait_done,
  output logic max_wait_expired,
  output logic link_stat,
  output logic pattern_four_order,
  output logic [7:0] pattern_seven_data
);
  // ===========================================================
  // Register storage
  logic [15:0] fec_ctrl_ff, code_sel_ff, code_cnt_ff;
  logic [15:0] upper_wait_ff, link_ctrl_ff, pattern_ff;
  logic [5:0] sel;
  logic wr_en;
  logic rd_en;

  // One-hot register select, all zero for an unmapped offset
  function automatic logic [5:0] reg_select(input logic [10:0] addr);
    if (addr == `OFS_FEC_DECODER_CTRL) begin
      reg_select = 6'h01;
    end else if (addr == `OFS_LOW_POWER_CODE_SELECT) begin
      reg_select = 6'h02;
    end else if (addr == `OFS_LOW_POWER_CODE_COUNT) begin
      reg_select = 6'h04;
    end else if (addr == `OFS_LINK_UP_UPPER_WAIT) begin
      reg_select = 6'h08;
    end else if (addr == `OFS_GIGABIT_LINK_CTRL) begin
      reg_select = 6'h10;
    end else if (addr == `OFS_COMPLIANCE_PATTERN_CTRL) begin
      reg_select = 6'h20;
    end else begin
      reg_select = 6'h00;
    end
  endfunction : reg_select

  // Read-only reserved bits are dropped on the way in
  function automatic logic [15:0] merge(input logic [15:0] mask,
                                        input logic [15:0] d);
    merge = d & mask;
  endfunction : merge

  assign sel = reg_select(mgmt.addr);
  assign wr_en = mgmt.req && mgmt.wr;
  assign rd_en = mgmt.req && !mgmt.wr;

  always_ff @(posedge clock) begin
    if (rst) begin
      fec_ctrl_ff <= `RST_FEC_DECODER_CTRL;
    end else if (wr_en && sel[0]) begin
      fec_ctrl_ff <= merge(`MASK_FEC_DECODER_CTRL, mgmt.wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      code_sel_ff <= `RST_LOW_POWER_CODE_SELECT;
    end else if (wr_en && sel[1]) begin
      code_sel_ff <= merge(`MASK_LOW_POWER_CODE_SELECT, mgmt.wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      code_cnt_ff <= `RST_LOW_POWER_CODE_COUNT;
    end else if (wr_en && sel[2]) begin
      code_cnt_ff <= merge(`MASK_LOW_POWER_CODE_COUNT, mgmt.wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      upper_wait_ff <= `RST_LINK_UP_UPPER_WAIT;
    end else if (wr_en && sel[3]) begin
      upper_wait_ff <= merge(`MASK_LINK_UP_UPPER_WAIT, mgmt.wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      link_ctrl_ff <= `RST_GIGABIT_LINK_CTRL;
    end else if (wr_en && sel[4]) begin
      link_ctrl_ff <= merge(`MASK_GIGABIT_LINK_CTRL, mgmt.wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pattern_ff <= `RST_COMPLIANCE_PATTERN_CTRL;
    end else if (wr_en && sel[5]) begin
      pattern_ff <= merge(`MASK_COMPLIANCE_PATTERN_CTRL, mgmt.wdata);
    end
  end

  // ===========================================================
  // Read path, unmapped reads return zero
  always_ff @(posedge clock) begin
    if (rst) begin
      mgmt_rdata <= 16'h0000;
      mgmt_ack <= 1'b0;
    end else begin
      mgmt_ack <= mgmt.req;
      if (rd_en) begin
        if (sel[0]) begin
          mgmt_rdata <= fec_ctrl_ff;
        end else if (sel[1]) begin
          mgmt_rdata <= code_sel_ff;
        end else if (sel[2]) begin
          mgmt_rdata <= code_cnt_ff;
        end else if (sel[3]) begin
          mgmt_rdata <= upper_wait_ff;
        end else if (sel[4]) begin
          mgmt_rdata <= link_ctrl_ff;
        end else if (sel[5]) begin
          mgmt_rdata <= pattern_ff;
        end else begin
          mgmt_rdata <= 16'h0000;
        end
      end
    end
  end

  // ===========================================================
  // Static controls
  always_ff @(posedge clock) begin
    if (rst) begin
      fec_decoder_skip <= 1'b0;
      outgoing_wake_code <= 3'h4;
      outgoing_sleep_code <= 3'h3;
    end else begin
      fec_decoder_skip <= fec_ctrl_ff[`BIT_FEC_SKIP]; // R1
      outgoing_wake_code <=
        code_sel_ff[`MSB_OUT_WAKE -: 3]; // R2
      outgoing_sleep_code <=
        code_sel_ff[`MSB_OUT_SLEEP -: 3]; // R3
    end
  end

  // Test pattern controls
  always_ff @(posedge clock) begin
    if (rst) begin
      pattern_four_order <= 1'b0;
      pattern_seven_data <= 8'h00;
    end else begin
      pattern_four_order <= pattern_ff[`BIT_PATTERN_ORDER]; // R12
      pattern_seven_data <= pattern_ff[7:0]; // R13
    end
  end

  // Forced value only counts while force enable is set
  always_ff @(posedge clock) begin
    if (rst) begin
      link_stat <= 1'b0;
    end else if (link_ctrl_ff[`BIT_FORCE_EN]) begin // R10
      link_stat <= link_ctrl_ff[`BIT_FORCE_VAL]; // R11
    end else begin
      link_stat <= link_stat_internal; // R11
    end
  end

  // ===========================================================
  // Wake and sleep code run counters
  logic [6:0] wake_run_ff, sleep_run_ff;
  logic [2:0] incoming_wake_code, incoming_sleep_code;
  logic [6:0] wake_run_threshold, sleep_run_threshold;
  logic is_wake, is_sleep;
  assign incoming_wake_code = code_sel_ff[`MSB_IN_WAKE -: 3];
  assign incoming_sleep_code = code_sel_ff[`MSB_IN_SLEEP -: 3];
  assign wake_run_threshold = code_cnt_ff[`MSB_WAKE_TH -: 7];
  assign sleep_run_threshold = code_cnt_ff[`MSB_SLEEP_TH -: 7];
  assign is_wake = rx_group.valid &&
                   (rx_group.code == incoming_wake_code); // R4
  assign is_sleep = rx_group.valid &&
                    (rx_group.code == incoming_sleep_code); // R5

  function automatic logic [6:0] run_step(input logic [6:0] cnt,
                                          input logic hit);
    if (!hit) begin
      run_step = 7'h00;
    end else if (cnt == 7'h7f) begin
      run_step = cnt;
    end else begin
      run_step = cnt + 7'h01;
    end
  endfunction : run_step

  // Idle cycles leave runs alone; any other valid group restarts them
  always_ff @(posedge clock) begin
    if (rst) begin
      wake_run_ff <= 7'h00;
      wake_cmd_received <= 1'b0;
    end else if (rx_group.valid) begin
      wake_run_ff <= run_step(wake_run_ff, is_wake);
      wake_cmd_received <= is_wake &&
        (run_step(wake_run_ff, 1'b1) >= wake_run_threshold); // R6
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sleep_run_ff <= 7'h00;
      sleep_cmd_received <= 1'b0;
    end else if (rx_group.valid) begin
      sleep_run_ff <= run_step(sleep_run_ff, is_sleep);
      sleep_cmd_received <= is_sleep &&
        (run_step(sleep_run_ff, 1'b1) >= sleep_run_threshold); // R7
    end
  end

  // ===========================================================
  // Link-up wait timers in 16 us units
  link_wait_e wait_state_ff;
  logic [15:0] unit_cnt_ff;
  logic [31:0] prescale_ff;
  logic unit_tick;
  assign unit_tick = (prescale_ff == 32'(UNIT_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (rst || wait_state_ff == wait_idle || unit_tick) begin
      prescale_ff <= 32'h0;
    end else begin
      prescale_ff <= prescale_ff + 32'h1;
    end
  end

  // Elapsed units, frozen once the upper wait expires
  always_ff @(posedge clock) begin
    if (rst || link_up_start) begin
      unit_cnt_ff <= 16'h0000;
    end else if (unit_tick && (wait_state_ff == wait_min ||
                               wait_state_ff == wait_max)) begin
      unit_cnt_ff <= unit_cnt_ff + 16'h0001;
    end
  end

  // Limits are read live, so a rewrite mid-wait applies at once
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_state_ff <= wait_idle;
      min_wait_done <= 1'b0;
      max_wait_expired <= 1'b0;
    end else if (link_up_start) begin
      wait_state_ff <= wait_min;
      min_wait_done <= 1'b0;
      max_wait_expired <= 1'b0;
    end else begin
      case (wait_state_ff)
        wait_idle: begin
        end
        wait_min, wait_max: begin
          if (unit_cnt_ff >= {8'h00, link_ctrl_ff[7:0]}) begin // R9
            min_wait_done <= 1'b1;
            wait_state_ff <= wait_max;
          end
          if (unit_cnt_ff >= upper_wait_ff) begin // R8
            max_wait_expired <= 1'b1;
            wait_state_ff <= wait_done;
          end
        end
        wait_done: begin
        end
        default: wait_state_ff <= wait_idle;
      endcase
    end
  end
endmodule : link_ctrl_regs
`default_nettype wire

/* sim/link_ctrl_regs_sva.sv */
// Port assertions for the link control register block
// Bound to the block from the bench top file
`default_nettype none
module link_ctrl_regs_sva
  import link_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire mgmt_req_s mgmt,
  input wire logic mgmt_ack,
  input wire code_group_s rx_group,
  input wire logic link_stat_internal,
  input wire logic fec_decoder_skip,
  input wire logic [2:0] outgoing_wake_code,
  input wire logic [2:0] outgoing_sleep_code,
  input wire logic wake_cmd_received,
  input wire logic sleep_cmd_received,
  input wire logic link_stat,
  input wire logic pattern_four_order,
  input wire logic [7:0] pattern_seven_data
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [15:0] d = mgmt.wdata;
  // Write strobe above the address, so one compare decodes a write
  wire logic [11:0] wa = {mgmt.req & mgmt.wr, mgmt.addr};
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_ack; mgmt.req |=> mgmt_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_skip;
    wa == 12'hd10 |=> ##1 fec_decoder_skip == $past(d[15], 2); endproperty
  a_skip: assert property (p_skip) else $error("bad skip");
  property p_wc;
    wa == 12'hd14 |=> ##1 outgoing_wake_code == $past(d[11:9], 2); endproperty
  a_wc: assert property (p_wc) else $error("bad wake code");
  property p_sc;
    wa == 12'hd14 |=> ##1 outgoing_sleep_code == $past(d[8:6], 2); endproperty
  a_sc: assert property (p_sc) else $error("bad sleep code");
  property p_frc;
    wa == 12'hd19 && d[10] |=> ##1 link_stat == $past(d[11], 2); endproperty
  a_frc: assert property (p_frc) else $error("bad forced");
  property p_free;
    wa == 12'hd19 && !d[10] |=> ##1 link_stat == $past(link_stat_internal);
  endproperty
  a_free: assert property (p_free) else $error("bad status");
  property p_pat; wa == 12'hd31 |=> ##1
    {pattern_four_order, pattern_seven_data} == $past(d[8:0], 2); endproperty
  a_pat: assert property (p_pat) else $error("bad pattern");
  property p_wake; $rose(wake_cmd_received) |-> $past(rx_group.valid);
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake flag");
  c_wake: cover property ($rose(wake_cmd_received));
  c_sleep: cover property ($rose(sleep_cmd_received));
  c_force: cover property (wa == 12'hd19 && d[10]);
endmodule : link_ctrl_regs_sva
`default_nettype wire

/* sim/link_partner_model.sv */
// Remote transceiver model sending code groups
// The bench calls send from its main sequence
`default_nettype none
module link_partner_model
  import link_ctrl_pkg::*;
(
  input wire logic clock,
  output var code_group_s rx_group
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_group = '0;
  // Idle cycles carry a flipped code so a stale value never matches
  task automatic send(logic [2:0] c, int n);
    repeat (n) begin
      @(posedge clock);
      rx_group <= '{c, 1'b1};
      @(posedge clock);
      rx_group <= '{~c, 1'b0};
    end
    #1;
  endtask : send
endmodule : link_partner_model
`default_nettype wire

/* sim/test_link_ctrl_regs.sv */
// Bench for the link control register block
// Needs the package, checker and partner model compiled first
`default_nettype none
module test_link_ctrl_regs
  import link_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst = 1'b1, link_up_start = 1'b0;
  logic link_stat_internal = 1'b0;
  mgmt_req_s mgmt = '0;
  code_group_s rx_group;
  logic mgmt_ack, fec_decoder_skip, wake_cmd_received, sleep_cmd_received;
  logic min_wait_done, max_wait_expired, link_stat, pattern_four_order;
  logic [2:0] outgoing_wake_code, outgoing_sleep_code;
  logic [7:0] pattern_seven_data;
  logic [15:0] mgmt_rdata, rd, d, mdl [6];
  logic [10:0] ofs [6] = '{11'h510, 11'h514, 11'h515, 11'h518, 11'h519,
    11'h531};
  logic [15:0] rv [6] = '{16'h2d50, 16'h08e3, 16'h0808, 16'h17ce, 16'h003d,
    16'h0000};
  logic [15:0] mk [6] = '{16'hffff, 16'h0fff, 16'h7f7f, 16'hffff, 16'h7fff,
    16'h01ff};
  int error_cnt = 0, check_count = 0, cyc = 0, seed = 76, i, n;
  always #2 clock = ~clock;
  link_partner_model lp (.clock(clock), .rx_group(rx_group));
  link_ctrl_regs #(.UNIT_CYCLES(4)) dut (.clock, .rst, .mgmt, .mgmt_rdata,
    .mgmt_ack, .rx_group, .link_up_start, .link_stat_internal,
    .fec_decoder_skip, .outgoing_wake_code, .outgoing_sleep_code,
    .wake_cmd_received, .sleep_cmd_received, .min_wait_done,
    .max_wait_expired, .link_stat, .pattern_four_order, .pattern_seven_data);
  task automatic chk(string s, logic [15:0] v, logic [15:0] e);
    check_count++;
    if (v !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", s, e, v);
    end
  endtask : chk
  task automatic acc(logic w, logic [10:0] a, logic [15:0] wd);
    @(posedge clock);
    mgmt <= '{1'b1, w, a, wd};
    @(posedge clock);
    mgmt.req <= 1'b0;
    #1 chk("ack", 16'(mgmt_ack), 16'h1);
    rd = mgmt_rdata;
  endtask : acc
  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      acc(1'b0, ofs[i], 16'h0);
      chk("reset", rd, rv[i]);
      d = 16'($random(seed));
      acc(1'b1, ofs[i], d);
      acc(1'b0, ofs[i], 16'h0);
      mdl[i] = d & mk[i];
      chk("readback", rd, mdl[i]);
    end
    acc(1'b0, 11'h520, 16'h0);
    chk("unmapped", rd, 16'h0);
    chk("skip", 16'(fec_decoder_skip), 16'(mdl[0][15]));
    chk("wake out", 16'(outgoing_wake_code), 16'(mdl[1][11:9]));
    chk("sleep out", 16'(outgoing_sleep_code), 16'(mdl[1][8:6]));
    chk("pattern", {7'h0, pattern_four_order, pattern_seven_data},
      16'(mdl[5][8:0]));
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      link_stat_internal <= 1'($random(seed));
      acc(1'b1, 11'h519, {4'h0, i[1], i[0], 10'h3});
      @(posedge clock);
      #1 chk("link", 16'(link_stat),
        16'(i[0] ? i[1] : link_stat_internal));
    end
    acc(1'b1, 11'h514, {4'h0, 3'd4, 3'd3, 3'd5, 3'd2});
    acc(1'b1, 11'h515, 16'h0803);
    for (n = 1; n < 10; n++) begin
      lp.send(3'd5, n);
      chk("wake", {14'h0, wake_cmd_received, sleep_cmd_received},
        16'(n >= 8) << 1);
      lp.send(3'd2, n);
      chk("sleep", {14'h0, wake_cmd_received, sleep_cmd_received},
        16'(n >= 3));
    end
    acc(1'b1, 11'h518, 16'h0005);
    @(posedge clock);
    link_up_start <= 1'b1;
    @(posedge clock);
    link_up_start <= 1'b0;
    repeat (8) @(posedge clock);
    #1 chk("min early", 16'(min_wait_done), 16'h0);
    repeat (8) @(posedge clock);
    #1 chk("min max", {14'h0, min_wait_done, max_wait_expired},
      16'h2);
    repeat (8) @(posedge clock);
    #1 chk("max", 16'(max_wait_expired), 16'h1);
    finish_test();
  end
endmodule : test_link_ctrl_regs
bind link_ctrl_regs link_ctrl_regs_sva chk_i (.clock, .rst, .mgmt,
  .mgmt_ack, .rx_group, .link_stat_internal, .fec_decoder_skip,
  .outgoing_wake_code, .outgoing_sleep_code, .wake_cmd_received,
  .sleep_cmd_received, .link_stat, .pattern_four_order, .pattern_seven_data);
`default_nettype wire
